// *** verilog/adc_chsel_consts.svh ***
// Offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADC_CHSEL_CONSTS_SVH
`define ADC_CHSEL_CONSTS_SVH
`define OFF_CHAN_SEL 8'h00
`define OFF_CTRL_A 8'h04
`define OFF_RESULT 8'h08
`define OFF_CTRL_B 8'h0C
`define OFF_IRQ_STATUS 8'h10
`define OFF_IRQ_MASK 8'h14
`define CTRLA_ENABLE 7
`define CTRLA_START 6
`define CTRLA_AUTO_TRIG 5
`define CTRLA_DONE 4
`define CTRLA_DONE_IE 3
`define CTRLB_FREE_RUN 0
`define CHAN_RESET 2'h0
`define RESULT_RESET 8'h00
`define RESULT_FULL_SCALE 8'hFF
`define CONV_CYCLES_NORMAL 8'h0D
`define CONV_CYCLES_FIRST 8'h19
`define SLEEP_IDLE 2'h1
`define SLEEP_NOISE_RED 2'h2
`endif

// *** verilog/adc_chsel_pkg.sv ***
// Types of the converter channel select and sequencing block
package adc_chsel_pkg;
   typedef enum logic [0:0] {CONV_IDLE, CONV_RUN} conv_state_t;
   typedef struct packed {
      conv_state_t st;
      logic [7:0] cyc;
      logic first;
      logic [6:0] presc;
      logic [1:0] chan_hold;
      logic [1:0] chan_act;
      logic en;
      logic start;
      logic auto_trig;
      logic done_flag;
      logic done_ie;
      logic [2:0] presc_sel;
      logic free_run;
      logic [7:0] result;
      logic irq_stat;
      logic irq_mask;
      logic [2:0] trig_sync;
      logic trig_prev;
      logic halt_prev;
      logic dp_wr;
      logic [7:0] dp_addr;
      logic [31:0] rdata;
      logic irq;
      logic ready;
   } adc_state_t;
endpackage : adc_chsel_pkg

// *** verilog/adc_channel_select_control.sv ***
// Converter channel select, conversion sequencing and AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "adc_chsel_consts.svh"

module adc_channel_select_control (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic trigger_in,
   input wire logic core_halted,
   input wire logic [1:0] sleep_mode,
   input wire logic [8:0] conv_level,
   output logic [1:0] channel_active,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [6:0] div_mask(input logic [2:0] sel);
      logic [6:0] m;
      m = 7'h01;
      if (sel > 3'h1) begin
         m = 7'((8'h01 << sel) - 8'h01);
      end
      return m;
   endfunction : div_mask

   function automatic logic [7:0] saturate(input logic [8:0] lvl);
      return lvl[8] ? `RESULT_FULL_SCALE : lvl[7:0];
   endfunction : saturate

   ////////////////////////////////////////////////////////////////////////
   adc_chsel_pkg::adc_state_t s_reg;
   adc_chsel_pkg::adc_state_t s_next;
   logic tick;
   logic last_cyc;
   logic complete;
   logic trig_edge;
   logic sleep_start;
   logic [7:0] conv_len;

   always_comb begin
      s_next = s_reg;
      conv_len = s_reg.first ? `CONV_CYCLES_FIRST : `CONV_CYCLES_NORMAL;
      tick = s_reg.en && ((s_reg.presc & div_mask(s_reg.presc_sel)) == div_mask(s_reg.presc_sel));
      last_cyc = (s_reg.st == adc_chsel_pkg::CONV_RUN) && (s_reg.cyc == conv_len - 8'h01);
      complete = last_cyc && tick;
      // Second and third stage agree on a rising edge
      trig_edge = s_reg.trig_sync[1] && s_reg.trig_sync[2] && !s_reg.trig_prev;
      sleep_start = core_halted && !s_reg.halt_prev && s_reg.en && !s_reg.start
         && (s_reg.st == adc_chsel_pkg::CONV_IDLE) && !s_reg.auto_trig && s_reg.done_ie
         && (sleep_mode == `SLEEP_IDLE || sleep_mode == `SLEEP_NOISE_RED);
      s_next.trig_sync = {s_reg.trig_sync[1:0], trigger_in};
      if (s_reg.trig_sync[1] == s_reg.trig_sync[2]) begin
         s_next.trig_prev = s_reg.trig_sync[2];
      end
      s_next.halt_prev = core_halted;
      s_next.presc = s_reg.en ? s_reg.presc + 7'h01 : 7'h00;
      s_next.ready = 1'b1;

      // Data phase of a write
      if (s_reg.dp_wr) begin
         case (s_reg.dp_addr)
            `OFF_CHAN_SEL: s_next.chan_hold = hwdata[1:0];
            `OFF_CTRL_A: begin
               s_next.en = hwdata[`CTRLA_ENABLE];
               s_next.auto_trig = hwdata[`CTRLA_AUTO_TRIG];
               s_next.done_ie = hwdata[`CTRLA_DONE_IE];
               s_next.presc_sel = hwdata[2:0];
               if (hwdata[`CTRLA_START] && hwdata[`CTRLA_ENABLE]) begin
                  s_next.start = 1'b1;
               end
               if (hwdata[`CTRLA_DONE]) begin
                  s_next.done_flag = 1'b0;
               end
            end
            `OFF_CTRL_B: s_next.free_run = hwdata[`CTRLB_FREE_RUN];
            `OFF_IRQ_MASK: s_next.irq_mask = hwdata[0];
            default: ;
         endcase
      end

      // Address phase: read data from post-write state, read clears status
      s_next.dp_wr = 1'b0;
      if (hsel && hready && htrans[1]) begin
         s_next.dp_wr = hwrite;
         s_next.dp_addr = haddr[7:0];
         if (!hwrite) begin
            case (haddr[7:0])
               `OFF_CHAN_SEL: s_next.rdata = {30'h0, s_next.chan_hold};
               `OFF_CTRL_A: s_next.rdata = {24'h0, s_next.en, s_next.start, s_next.auto_trig,
                  s_next.done_flag, s_next.done_ie, s_next.presc_sel};
               `OFF_RESULT: s_next.rdata = {24'h0, s_reg.result};
               `OFF_CTRL_B: s_next.rdata = {31'h0, s_next.free_run};
               `OFF_IRQ_STATUS: begin
                  s_next.rdata = {31'h0, s_reg.irq_stat};
                  s_next.irq_stat = 1'b0;
               end
               `OFF_IRQ_MASK: s_next.rdata = {31'h0, s_next.irq_mask};
               default: s_next.rdata = 32'h0000_0000;
            endcase
         end
      end

      // Holding register reaches the converter only at safe points
      if (s_reg.st == adc_chsel_pkg::CONV_IDLE) begin
         s_next.chan_act = s_reg.chan_hold;
      end else if (last_cyc) begin
         s_next.chan_act = s_reg.chan_hold;
      end

      // Sequencing; completion comes last so a set beats a clear
      case (s_reg.st)
         adc_chsel_pkg::CONV_IDLE: begin
            if (sleep_start) begin
               s_next.start = 1'b1;
            end
            if (s_reg.en && s_reg.auto_trig && !s_reg.free_run && trig_edge) begin
               s_next.presc = 7'h00;
               s_next.start = 1'b1;
               s_next.st = adc_chsel_pkg::CONV_RUN;
               s_next.cyc = 8'h00;
            end else if (s_reg.start && tick) begin
               s_next.st = adc_chsel_pkg::CONV_RUN;
               s_next.cyc = 8'h00;
            end
         end
         adc_chsel_pkg::CONV_RUN: begin
            if (complete) begin
               s_next.result = saturate(conv_level);
               s_next.done_flag = 1'b1;
               s_next.irq_stat = 1'b1;
               s_next.first = 1'b0;
               s_next.cyc = 8'h00;
               // Free running restarts at once with start still high
               if (!(s_reg.auto_trig && s_reg.free_run)) begin
                  s_next.start = 1'b0;
                  s_next.st = adc_chsel_pkg::CONV_IDLE;
               end
            end else if (tick) begin
               s_next.cyc = s_reg.cyc + 8'h01;
            end
         end
         default: s_next.st = adc_chsel_pkg::CONV_IDLE;
      endcase

      // Disabling aborts and rearms the long first conversion; sleep has no say here
      if (!s_next.en) begin
         s_next.st = adc_chsel_pkg::CONV_IDLE;
         s_next.start = 1'b0;
         s_next.first = 1'b1;
         s_next.cyc = 8'h00;
      end
      s_next.irq = s_next.irq_stat && s_next.irq_mask;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= '0;
         s_reg.first <= 1'b1;
         s_reg.ready <= 1'b1;
         s_reg.chan_hold <= `CHAN_RESET;
         s_reg.chan_act <= `CHAN_RESET;
         s_reg.result <= `RESULT_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign hrdata = s_reg.rdata;
   assign hreadyout = s_reg.ready;
   assign hresp = 1'b0;
   assign channel_active = s_reg.chan_act;
   assign irq = s_reg.irq;

   ////////////////////////////////////////////////////////////////////////
   logic [7:0] tick_cnt;
   logic long_run;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt <= 8'h00;
         long_run <= 1'b0;
      end else if (s_reg.st == adc_chsel_pkg::CONV_IDLE || complete) begin
         tick_cnt <= 8'h00;
         long_run <= s_next.first;
      end else if (tick) begin
         tick_cnt <= tick_cnt + 8'h01;
      end
   end

   default clocking dflt @(posedge hclk); endclocking
   default disable iff (!hresetn);

   chan_frozen_a: assert property (
      (s_reg.st == adc_chsel_pkg::CONV_RUN && !last_cyc) |=> $stable(channel_active))
      else $error("channel changed during conversion");
   chan_follow_a: assert property (
      (s_reg.st == adc_chsel_pkg::CONV_IDLE) |=> channel_active == $past(s_reg.chan_hold))
      else $error("idle channel not following holding register");
   last_copy_a: assert property (
      last_cyc |=> channel_active == $past(s_reg.chan_hold))
      else $error("no copy in last cycle");
   start_tick_a: assert property (
      (s_reg.st == adc_chsel_pkg::CONV_IDLE && s_reg.start && tick && s_next.en)
      |=> s_reg.st == adc_chsel_pkg::CONV_RUN && s_reg.cyc == 8'h00)
      else $error("conversion did not begin on tick");
   saturate_a: assert property (
      (complete && conv_level[8]) |=> s_reg.result == 8'hFF)
      else $error("result not saturated");
   conv_len_a: assert property (
      complete |-> tick_cnt == (long_run ? 8'h18 : 8'h0C))
      else $error("wrong conversion length");
   start_clear_a: assert property (
      (complete && !(s_reg.auto_trig && s_reg.free_run)) |=> !s_reg.start && s_reg.done_flag)
      else $error("start not cleared");
   busy_start_a: assert property (
      (s_reg.st == adc_chsel_pkg::CONV_RUN) |-> s_reg.start)
      else $error("start low while converting");
   sleep_start_a: assert property (
      (sleep_start && s_next.en) |=> s_reg.start)
      else $error("sleep entry did not start");
   done_irq_a: assert property (
      (complete && s_next.irq_mask) |=> irq && s_reg.done_flag)
      else $error("completion gave no request");
   reserved_a: assert property (
      (hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h00) |=> hrdata[31:2] == 30'h0)
      else $error("reserved channel bits nonzero");

   single_cov_c: cover property (complete && !s_reg.free_run);
   free_run_c: cover property (complete && s_reg.free_run && s_reg.auto_trig);
   sleep_cov_c: cover property (sleep_start ##[1:1000] complete);
   trig_cov_c: cover property (trig_edge && s_reg.auto_trig && s_reg.st == adc_chsel_pkg::CONV_IDLE);

endmodule : adc_channel_select_control
`default_nettype wire

// *** tb/adc_channel_select_control_tb_top.sv ***
// Self-checking testbench of the converter channel select and sequencing block
`timescale 1ns/1ps
`default_nettype none
`include "adc_chsel_consts.svh"
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
   $display("BAD %0t %s", $time, msg); end end

module adc_channel_select_control_tb_top;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic trigger_in = 1'b0;
   logic core_halted = 1'b0;
   logic [1:0] sleep_mode = 2'h0;
   logic [8:0] conv_level = 9'h000;
   wire logic [31:0] hrdata;
   wire logic hreadyout;
   wire logic hresp;
   wire logic [1:0] channel_active;
   wire logic irq;
   int n_fail = 0;
   int total_checks = 0;
   int cyc = 0;

   adc_channel_select_control i_adc_channel_select_control (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .trigger_in(trigger_in),
      .core_halted(core_halted), .sleep_mode(sleep_mode), .conv_level(conv_level),
      .channel_active(channel_active), .irq(irq)
   );

   initial begin
      forever #5 hclk = ~hclk;
   end

   always @(posedge hclk) cyc++;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus cycles and helpers
   task automatic bus_cycle(input logic [7:0] a, input logic wr, input logic [31:0] d,
                            output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      `CHK(hresp, 1'b0, "response not OKAY")
   endtask : bus_cycle

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus_cycle(a, 1'b1, d, x);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] x;
      bus_cycle(a, 1'b0, 32'h00000000, x);
      `CHK(x & m, e, "register read")
   endtask : rd_chk

   // Edges until irq; a hang counts as a mismatch
   task automatic wait_irq(input int lo, input int hi);
      int t0;
      t0 = cyc;
      while (irq !== 1'b1 && cyc - t0 < 400) @(posedge hclk);
      `CHK((cyc - t0 >= lo) && (cyc - t0 <= hi), 1'b1, "conversion length")
   endtask : wait_irq

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic s_regs();
      rd_chk(`OFF_CHAN_SEL, 32'hFFFFFFFF, 32'h00000000);
      for (int v = 0; v < 4; v++) begin
         wr(`OFF_CHAN_SEL, 32'hFFFFFFFC | v);
         rd_chk(`OFF_CHAN_SEL, 32'hFFFFFFFF, v);
         `CHK(channel_active, 2'(v), "idle channel copy")
      end
      rd_chk(8'h20, 32'hFFFFFFFF, 32'h00000000);
   endtask : s_regs

   // First conversion: 25 ticks at divide by 2, channel frozen meanwhile
   task automatic s_first();
      wr(`OFF_CHAN_SEL, 32'h00000001);
      wr(`OFF_IRQ_MASK, 32'h00000001);
      conv_level <= 9'h05A;
      wr(`OFF_CTRL_A, 32'h000000C9);
      fork
         wait_irq(49, 56);
         begin
            rd_chk(`OFF_CTRL_A, 32'h00000040, 32'h00000040);
            wr(`OFF_CHAN_SEL, 32'h00000002);
            `CHK(channel_active, 2'h1, "channel not frozen")
         end
      join
      `CHK(channel_active, 2'h2, "channel not released")
      rd_chk(`OFF_RESULT, 32'hFFFFFFFF, 32'h0000005A);
      rd_chk(`OFF_CTRL_A, 32'h00000050, 32'h00000010);
   endtask : s_first

   // Normal conversion with an input above the reference; mask and clear
   task automatic s_normal();
      rd_chk(`OFF_IRQ_STATUS, 32'h00000001, 32'h00000001);
      `CHK(irq, 1'b0, "irq not cleared by read")
      conv_level <= 9'h123;
      wr(`OFF_CTRL_A, 32'h000000C9);
      wait_irq(25, 32);
      rd_chk(`OFF_RESULT, 32'hFFFFFFFF, {24'h000000, `RESULT_FULL_SCALE});
      wr(`OFF_IRQ_MASK, 32'h00000000);
      // The mask and irq both land at the last bus edge; the check samples one edge later
      @(posedge hclk);
      `CHK(irq, 1'b0, "masked irq high")
      wr(`OFF_IRQ_MASK, 32'h00000001);
      @(posedge hclk);
      `CHK(irq, 1'b1, "unmasked irq low")
      rd_chk(`OFF_IRQ_STATUS, 32'h00000001, 32'h00000001);
   endtask : s_normal

   // Start on halt only in idle and noise-reduction sleep
   task automatic s_sleep();
      conv_level <= 9'h033;
      wr(`OFF_CTRL_A, 32'h00000089);
      sleep_mode <= 2'h0;
      core_halted <= 1'b1;
      rd_chk(`OFF_CTRL_A, 32'h000000C0, 32'h00000080);
      core_halted <= 1'b0;
      sleep_mode <= `SLEEP_NOISE_RED;
      @(posedge hclk);
      core_halted <= 1'b1;
      rd_chk(`OFF_CTRL_A, 32'h00000040, 32'h00000040);
      core_halted <= 1'b0;
      wait_irq(1, 32);
      rd_chk(`OFF_RESULT, 32'hFFFFFFFF, 32'h00000033);
      rd_chk(`OFF_IRQ_STATUS, 32'h00000001, 32'h00000001);
   endtask : s_sleep

   // Trigger edge starts; a second edge while busy is ignored
   task automatic s_trig();
      sleep_mode <= 2'h0;
      wr(`OFF_CTRL_A, 32'h000000A9);
      trigger_in <= 1'b1;
      repeat (6) @(posedge hclk);
      trigger_in <= 1'b0;
      rd_chk(`OFF_CTRL_A, 32'h00000040, 32'h00000040);
      wr(`OFF_CHAN_SEL, 32'h00000003);
      `CHK(channel_active, 2'h2, "triggered conversion took new channel")
      trigger_in <= 1'b1;
      wait_irq(1, 32);
      `CHK(channel_active, 2'h3, "channel not applied to next conversion")
      repeat (8) @(posedge hclk);
      rd_chk(`OFF_CTRL_A, 32'h00000040, 32'h00000000);
   endtask : s_trig

   // Free running: a channel change after the first completion applies one conversion later
   task automatic s_free();
      rd_chk(`OFF_IRQ_STATUS, 32'h00000001, 32'h00000001);
      wr(`OFF_CTRL_B, 32'h00000001);
      wr(`OFF_CTRL_A, 32'h000000E9);
      wait_irq(25, 32);
      rd_chk(`OFF_IRQ_STATUS, 32'h00000001, 32'h00000001);
      wr(`OFF_CHAN_SEL, 32'h00000001);
      `CHK(channel_active, 2'h3, "running conversion took new channel")
      wait_irq(1, 32);
      `CHK(channel_active, 2'h1, "channel stuck after free-run completion")
      rd_chk(`OFF_CTRL_A, 32'h00000040, 32'h00000040);
      wr(`OFF_CTRL_A, 32'h00000000);
      wr(`OFF_CTRL_B, 32'h00000000);
      rd_chk(`OFF_IRQ_STATUS, 32'h00000001, 32'h00000001);
   endtask : s_free

   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (20000) @(posedge hclk);
      `CHK(1'b0, 1'b1, "watchdog expired")
      summarize();
   end

   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      `CHK(channel_active, 2'h0, "channel after reset")
      `CHK(hreadyout, 1'b1, "ready after reset")
      `CHK(irq, 1'b0, "irq after reset")
      `CHK(hrdata, 32'h00000000, "read data after reset")
      s_regs();
      s_first();
      s_normal();
      s_sleep();
      s_trig();
      s_free();
      summarize();
   end
endmodule : adc_channel_select_control_tb_top
`default_nettype wire
